// File: logic/fwp_pkg.sv
// Package: constants for the flash write guard and programming status block
`default_nettype none
package fwp_pkg;
  // Flash command register codes
  localparam logic [7:0] CMD_SET_WE = 8'h08;
  localparam logic [7:0] CMD_CLR_WE = 8'h0B;
  localparam logic [7:0] KEY_VALUE = 8'h96;
  // Programming call function codes
  localparam logic [7:0] FN_PAGE_PROG = 8'h00;
  localparam logic [7:0] FN_VERSION = 8'h01;
  localparam logic [7:0] FN_MISC_WRITE = 8'h02;
  // Misc write index decoding
  localparam logic [7:0] IDX_CFG_LAST = 8'h03;
  localparam logic [7:0] IDX_SEC_FIRST = 8'h08;
  localparam logic [7:0] IDX_SEC_LAST = 8'h0F;
  localparam logic [7:0] IDX_CLR_PROT = 8'h10;
  localparam logic [7:0] IDX_BOOT_STATUS = 8'h03;
  // Boot status byte fields
  localparam int BS_ACTIVATE_BIT = 7;
  localparam int BS_CWP_BIT = 6;
  // Error status fields
  localparam int ERR_INTR_BIT = 0;
  localparam int ERR_SEC_BIT = 1;
  localparam int ERR_PUMP_BIT = 2;
  localparam int ERR_VERIFY_BIT = 3;
  // Register addresses on the plain port
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_KEY = 4'h1;
  localparam logic [3:0] ADDR_FUNC = 4'h2;
  localparam logic [3:0] ADDR_INDEX = 4'h3;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_AUTH = 4'h5;
  localparam logic [3:0] ADDR_GO = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_FLAGS = 4'h8;
  localparam logic [3:0] ADDR_BOOT_STATUS_BYTE = 4'h9;
  // Reset values
  localparam logic [7:0] BOOT_STATUS_RESET = 8'h00;
  localparam logic [7:0] VERSION_ID = 8'h01; // Arbitrary value
  // Self-timed cycle length
  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLE_TIME_US = 2000;
  localparam int CYCLE_COUNT = CYCLE_TIME_US * (CLK_HZ / 1_000_000);
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b10
  } fwp_state_type;
endpackage
`default_nettype wire

// File: logic/fwp_guard.sv
// Flash write guard, configuration protection and programming status logic
//
// Design decisions made here: the register offsets and the strobed register port.
`default_nettype none
module fwp_guard #(
  parameter int CYCLE_CYCLES = fwp_pkg::CYCLE_COUNT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Mode and system events
  input wire logic serial_loader_mode,
  input wire logic application_call_mode,
  input wire logic irq_pending,
  input wire logic pump_fault,
  input wire logic readback_mismatch,
  input wire logic security_deny,
  // Core outputs
  output logic cpu_program_idle,
  output logic flash_write_strobe,
  output logic [7:0] flash_write_index,
  output logic [7:0] flash_write_data,
  output logic reset_request,
  output logic write_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fwp_pkg::fwp_state_type state;
  fwp_pkg::fwp_state_type next_state;
  logic we_flag;
  logic cmd_pending_set;
  logic cmd_pending_clr;
  logic [7:0] boot_status_byte;
  logic [7:0] func_code;
  logic [7:0] call_index;
  logic [7:0] call_data;
  logic [7:0] auth_key;
  logic [7:0] err_status;
  logic carry;
  logic [31:0] cycle_cnt;
  logic is_misc_wr;
  logic [7:0] next_err;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire guarded_mode = serial_loader_mode | application_call_mode;
  wire write_guard_activate = boot_status_byte[fwp_pkg::BS_ACTIVATE_BIT];
  wire config_write_protect = boot_status_byte[fwp_pkg::BS_CWP_BIT];
  wire lock_clear_protect_cmd = boot_status_byte[fwp_pkg::BS_ACTIVATE_BIT];
  wire wr_cmd = reg_wr && (reg_addr == fwp_pkg::ADDR_CMD);
  wire wr_key = reg_wr && (reg_addr == fwp_pkg::ADDR_KEY);
  wire wr_go = reg_wr && (reg_addr == fwp_pkg::ADDR_GO);
  wire key_ok = reg_wdata == fwp_pkg::KEY_VALUE;
  // Write enable is forced while the activate bit is clear
  wire we_eff = ~write_guard_activate | we_flag;
  wire is_cfg_idx = call_index <= fwp_pkg::IDX_CFG_LAST;
  wire is_sec_idx = (call_index >= fwp_pkg::IDX_SEC_FIRST) &&
                    (call_index <= fwp_pkg::IDX_SEC_LAST);
  wire is_clr_idx = call_index == fwp_pkg::IDX_CLR_PROT;
  wire keyed_fn = (func_code == fwp_pkg::FN_PAGE_PROG) ||
                  (func_code == fwp_pkg::FN_MISC_WRITE);
  // Gating is bypassed outside loader and call modes
  wire we_block = guarded_mode && !we_eff;
  wire cwp_block = guarded_mode && config_write_protect &&
                   is_cfg_idx;
  wire ccp_refuse = guarded_mode && lock_clear_protect_cmd;
  wire go_misc = func_code == fwp_pkg::FN_MISC_WRITE;
  wire call_denied = go_misc ?
    (is_clr_idx ? ccp_refuse :
     (we_block && (is_cfg_idx || is_sec_idx)) || cwp_block) :
    (we_block || security_deny);
  wire cycle_end = cycle_cnt >= CYCLE_CYCLES - 1;
  wire abort_now = irq_pending || pump_fault;

  assign write_enable = we_eff;
  assign cpu_program_idle = state == fwp_pkg::ST_BUSY;

  // ----------------------------------------------------------------
  // Write enable command sequence
  // ----------------------------------------------------------------
  // Key must immediately follow the command write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_pending_set <= 1'b0;
      cmd_pending_clr <= 1'b0;
    end else if (reg_wr) begin
      cmd_pending_set <= wr_cmd && (reg_wdata == fwp_pkg::CMD_SET_WE);
      cmd_pending_clr <= wr_cmd && (reg_wdata == fwp_pkg::CMD_CLR_WE);
    end
  end

  // Flag: reset clears, sequences set and clear; routine clears after writes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      we_flag <= 1'b0;
    end else if (wr_key && key_ok && cmd_pending_set) begin
      we_flag <= 1'b1;
    end else if (wr_key && key_ok && cmd_pending_clr) begin
      we_flag <= 1'b0;
    end else if (state == fwp_pkg::ST_DONE) begin
      we_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Call parameters and authorization
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      func_code <= 8'h00;
      call_index <= 8'h00;
      call_data <= 8'h00;
      auth_key <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == fwp_pkg::ADDR_FUNC) func_code <= reg_wdata;
      if (reg_wr && reg_addr == fwp_pkg::ADDR_INDEX) call_index <= reg_wdata;
      if (reg_wr && reg_addr == fwp_pkg::ADDR_DATA) call_data <= reg_wdata;
      if (reg_wr && reg_addr == fwp_pkg::ADDR_AUTH) begin
        auth_key <= reg_wdata;
      end else if (wr_go) begin
        auth_key <= 8'h00;
      end
    end
  end

  // Missing key on a keyed call asks for a reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_request <= 1'b0;
    end else begin
      reset_request <= wr_go && keyed_fn &&
                       (auth_key != fwp_pkg::KEY_VALUE);
    end
  end

  // ----------------------------------------------------------------
  // Self-timed cycle sequencer
  // ----------------------------------------------------------------
  wire go_ok = wr_go && keyed_fn && (auth_key == fwp_pkg::KEY_VALUE);
  always_comb begin
    next_state = state;
    unique case (state)
      fwp_pkg::ST_IDLE: if (go_ok && !call_denied) begin
        next_state = fwp_pkg::ST_BUSY;
      end
      fwp_pkg::ST_BUSY: if (abort_now || cycle_end) begin
        next_state = fwp_pkg::ST_DONE;
      end
      fwp_pkg::ST_DONE: next_state = fwp_pkg::ST_IDLE;
      default: next_state = fwp_pkg::ST_IDLE;
    endcase
  end

  // Error byte built from the cause of the ending
  always_comb begin
    next_err = 8'h00;
    if (state == fwp_pkg::ST_IDLE) begin
      next_err[fwp_pkg::ERR_SEC_BIT] = call_denied;
    end else begin
      next_err[fwp_pkg::ERR_INTR_BIT] = irq_pending;
      next_err[fwp_pkg::ERR_PUMP_BIT] = pump_fault;
      next_err[fwp_pkg::ERR_VERIFY_BIT] = !abort_now && !go_misc &&
                                          readback_mismatch;
    end
  end

  assign is_misc_wr = go_misc && !is_clr_idx;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= fwp_pkg::ST_IDLE;
      cycle_cnt <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (state == fwp_pkg::ST_BUSY) begin
        cycle_cnt <= cycle_cnt + 32'h0000_0001;
      end else begin
        cycle_cnt <= 32'h0000_0000;
      end
    end
  end

  // Status and carry latched at call end or refusal
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_status <= 8'h00;
      carry <= 1'b0;
    end else if (state == fwp_pkg::ST_IDLE && go_ok) begin
      err_status <= next_err;
      carry <= call_denied;
    end else if (state == fwp_pkg::ST_BUSY && next_state != state) begin
      err_status <= next_err;
      carry <= |next_err;
    end
  end

  // Commit of the stored byte at a clean cycle end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_status_byte <= fwp_pkg::BOOT_STATUS_RESET;
      flash_write_strobe <= 1'b0;
      flash_write_index <= 8'h00;
      flash_write_data <= 8'h00;
    end else begin
      flash_write_strobe <= 1'b0;
      if (state == fwp_pkg::ST_BUSY && cycle_end && !abort_now) begin
        flash_write_strobe <= is_misc_wr;
        flash_write_index <= call_index;
        flash_write_data <= call_data;
        if (go_misc && is_clr_idx) begin
          boot_status_byte[fwp_pkg::BS_CWP_BIT] <= 1'b0;
          if (!guarded_mode) begin
            boot_status_byte[fwp_pkg::BS_ACTIVATE_BIT] <= 1'b0;
          end
        end else if (is_misc_wr &&
                     call_index == fwp_pkg::IDX_BOOT_STATUS) begin
          boot_status_byte <= call_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire [7:0] rd_mux =
    (reg_addr == fwp_pkg::ADDR_STATUS) ? {4'h0, err_status[3:0]} :
    (reg_addr == fwp_pkg::ADDR_FLAGS) ?
      {5'h00, cpu_program_idle, we_eff, carry} :
    (reg_addr == fwp_pkg::ADDR_BOOT_STATUS_BYTE) ? boot_status_byte :
    (reg_addr == fwp_pkg::ADDR_FUNC) ? func_code : 8'h00;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Cleared activate bit leaves writes open
  a_we_forced: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !write_guard_activate |-> write_enable)
    else $error("write enable not forced");
  // Set command with key raises the flag
  a_we_set_seq: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $past(cmd_pending_set) && $past(wr_key) && $past(key_ok) |-> we_flag)
    else $error("set sequence missed");
  // Clear command with key drops the flag
  a_we_clr_seq: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (cmd_pending_clr && wr_key && key_ok) |=> !we_flag)
    else $error("clear sequence missed");
  // Flag only rises through the set sequence
  a_we_no_rise: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (!we_flag && !(cmd_pending_set && wr_key && key_ok)) |=> !we_flag)
    else $error("write enable rose without key");
  // Flag dropped after every finished call
  a_we_after_call: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state == fwp_pkg::ST_DONE && !(cmd_pending_set && wr_key && key_ok))
    |=> !we_flag)
    else $error("write enable kept after call");
  // Program idle holds two cycles unless the cycle ends or aborts after one
  a_idle_hold: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(cpu_program_idle) |-> cpu_program_idle [*2]
    or ##1 (state == fwp_pkg::ST_DONE))
    else $error("idle not held");
  // Interrupt ends a running cycle with its flag and carry
  a_irq_abort: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (cpu_program_idle && irq_pending) |=>
    (!cpu_program_idle && err_status[fwp_pkg::ERR_INTR_BIT] && carry))
    else $error("interrupt did not abort");
  // Pump fault aborts with no commit
  a_pump_abort: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (cpu_program_idle && pump_fault) |=>
    (!cpu_program_idle && err_status[fwp_pkg::ERR_PUMP_BIT] && carry &&
     !flash_write_strobe))
    else $error("pump fault did not abort");
  // Unused status bits stay clear
  a_status_hi: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    err_status[7:4] == 4'h0)
    else $error("unused status bits set");
  // Status read never shows the unused bits
  a_rdata_hi: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == fwp_pkg::ADDR_STATUS) |=> reg_rdata[7:4] == 4'h0)
    else $error("unused status bits read");
  // Protected configuration write refused and reported
  a_cwp_block: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state == fwp_pkg::ST_IDLE && go_ok && go_misc && cwp_block) |=>
    (state == fwp_pkg::ST_IDLE && carry))
    else $error("protected write not refused");
  // Locked clear command refused in guarded modes
  a_ccp_refuse: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (state == fwp_pkg::ST_IDLE && go_ok && go_misc && is_clr_idx &&
     ccp_refuse) |=> (state == fwp_pkg::ST_IDLE && carry))
    else $error("locked clear not refused");
  // Keyed call without the key asks for a reset
  a_no_key_rst: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_go && keyed_fn && auth_key != fwp_pkg::KEY_VALUE) |=>
    reset_request)
    else $error("missing key no reset");
  // Commit strobe is a single cycle
  a_strobe_pulse: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    flash_write_strobe |=> !flash_write_strobe)
    else $error("write strobe too long");

endmodule
`default_nettype wire

// File: tb/test_flash_write_protect_iap_status.sv
// Self-checking bench for the flash write guard and status block
`default_nettype none
module test_flash_write_protect_iap_status;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals and instance
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic serial_loader_mode = 1'b1;
  logic application_call_mode = 1'b0;
  logic irq_pending = 1'b0;
  logic pump_fault = 1'b0;
  logic readback_mismatch = 1'b0;
  logic security_deny = 1'b0;
  logic [7:0] reg_rdata, flash_write_index, flash_write_data;
  logic cpu_program_idle, flash_write_strobe, reset_request, write_enable;
  logic [7:0] v, seen_idx, seen_dat;
  int fail_count = 0;
  int checked = 0;
  int strobes = 0;
  int resets = 0;
  // Function codes used by the scenarios
  localparam logic [7:0] FN_PP = fwp_pkg::FN_PAGE_PROG;
  localparam logic [7:0] FN_MW = fwp_pkg::FN_MISC_WRITE;

  fwp_guard #(.CYCLE_CYCLES(8)) i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_loader_mode(serial_loader_mode),
    .application_call_mode(application_call_mode),
    .irq_pending(irq_pending), .pump_fault(pump_fault),
    .readback_mismatch(readback_mismatch), .security_deny(security_deny),
    .cpu_program_idle(cpu_program_idle),
    .flash_write_strobe(flash_write_strobe),
    .flash_write_index(flash_write_index),
    .flash_write_data(flash_write_data), .reset_request(reset_request),
    .write_enable(write_enable)
  );

  // 100 ns clock
  always #50 ref_clk = ~ref_clk;

  // Count strobe and reset pulses
  always @(negedge ref_clk) begin
    if (flash_write_strobe === 1'b1) begin
      strobes++;
      seen_idx = flash_write_index;
      seen_dat = flash_write_data;
    end
    if (reset_request === 1'b1) begin
      resets++;
    end
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenario tasks
  // ----------------------------------------
  // Keyed call; busy bit1 and stat bit8 mean do not check
  task automatic call(input logic [7:0] fn, idx, dat,
      input logic [1:0] busy, ev, input logic strb, cy,
      input logic [8:0] stat);
    int s0;
    s0 = strobes;
    wr(fwp_pkg::ADDR_AUTH, fwp_pkg::KEY_VALUE);
    wr(fwp_pkg::ADDR_FUNC, fn);
    wr(fwp_pkg::ADDR_INDEX, idx);
    wr(fwp_pkg::ADDR_DATA, dat);
    wr(fwp_pkg::ADDR_GO, 8'h00);
    @(negedge ref_clk);
    if (!busy[1]) begin
      chk("idle", {7'h00, busy[0]}, {7'h00, cpu_program_idle});
    end
    if (ev != 2'b00) begin
      repeat (3) @(posedge ref_clk);
      irq_pending <= ev[0];
      pump_fault <= ev[1];
    end
    for (int i = 0; i < 40 && cpu_program_idle === 1'b1; i++) begin
      @(negedge ref_clk);
    end
    chk("idle end", 8'h00, {7'h00, cpu_program_idle});
    @(posedge ref_clk);
    irq_pending <= 1'b0;
    pump_fault <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(fwp_pkg::ADDR_FLAGS, v);
    chk("carry", {7'h00, cy}, {7'h00, v[0]});
    rd(fwp_pkg::ADDR_STATUS, v);
    if (!stat[8]) chk("status", stat[7:0], v);
    chk("strobes", {7'h00, strb}, 8'(strobes - s0));
    if (strb) begin
      chk("index", idx, seen_idx);
      chk("data", dat, seen_dat);
    end
  endtask

  // Command then key; gap puts another write between them
  task automatic keyed(input logic [7:0] cmd, input logic gap, we);
    wr(fwp_pkg::ADDR_CMD, cmd);
    if (gap) wr(fwp_pkg::ADDR_FUNC, 8'h00);
    wr(fwp_pkg::ADDR_KEY, fwp_pkg::KEY_VALUE);
    @(negedge ref_clk);
    chk("write enable", {7'h00, we}, {7'h00, write_enable});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Defaults after reset: forced enable, empty byte, quiet holes
  task automatic t_reset_state();
    @(negedge ref_clk);
    chk("forced enable", 8'h01, {7'h00, write_enable});
    rd(fwp_pkg::ADDR_BOOT_STATUS_BYTE, v);
    chk("boot status", 8'h00, v);
    rd(4'hF, v);
    chk("unmapped", 8'h00, v);
  endtask

  // Page program: clean, readback error, interrupt, pump fault, refused
  task automatic t_page_prog();
    call(FN_PP, 8'h00, 8'h00, 2'h1, 2'h0, 1'h0, 1'h0, 9'h000);
    @(posedge ref_clk);
    readback_mismatch <= 1'h1;
    call(FN_PP, 8'h00, 8'h00, 2'h1, 2'h0, 1'h0, 1'h1, 9'h008);
    @(posedge ref_clk);
    readback_mismatch <= 1'h0;
    call(FN_PP, 8'h00, 8'h00, 2'h1, 2'h1, 1'h0, 1'h1, 9'h001);
    call(FN_PP, 8'h00, 8'h00, 2'h1, 2'h2, 1'h0, 1'h1, 9'h004);
    @(posedge ref_clk);
    security_deny <= 1'h1;
    call(FN_PP, 8'h00, 8'h00, 2'h0, 2'h0, 1'h0, 1'h1, 9'h002);
    @(posedge ref_clk);
    security_deny <= 1'h0;
  endtask

  // Go without the key asks for exactly one reset
  task automatic t_missing_key();
    int r0;
    r0 = resets;
    wr(fwp_pkg::ADDR_FUNC, FN_PP);
    rd(fwp_pkg::ADDR_FUNC, v);
    chk("function", FN_PP, v);
    wr(fwp_pkg::ADDR_GO, 8'h00);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset pulses", 8'h01, 8'(resets - r0));
    chk("keyless idle", 8'h00, {7'h00, cpu_program_idle});
  endtask

  // Loader mode misc writes; the boot byte write arms the guard
  task automatic t_loader_writes();
    call(FN_MW, 8'h01, 8'h5A, 2'h1, 2'h0, 1'h1, 1'h0, 9'h000);
    call(FN_MW, 8'h03, 8'h80, 2'h1, 2'h0, 1'h1, 1'h0, 9'h000);
    chk("enable off", 8'h00, {7'h00, write_enable});
  endtask

  // Set, clear, and a set broken by another write
  task automatic t_key_seq();
    keyed(fwp_pkg::CMD_SET_WE, 1'h0, 1'h1);
    keyed(fwp_pkg::CMD_CLR_WE, 1'h0, 1'h0);
    keyed(fwp_pkg::CMD_SET_WE, 1'h1, 1'h0);
  endtask

  // Call mode: guard, protect bit and locked clear command
  task automatic t_call_mode();
    @(posedge ref_clk);
    serial_loader_mode <= 1'h0;
    application_call_mode <= 1'h1;
    call(FN_MW, 8'h00, 8'h11, 2'h0, 2'h0, 1'h0, 1'h1, 9'h002);
    keyed(fwp_pkg::CMD_SET_WE, 1'h0, 1'h1);
    call(FN_MW, 8'h03, 8'hC0, 2'h1, 2'h0, 1'h1, 1'h0, 9'h000);
    keyed(fwp_pkg::CMD_SET_WE, 1'h0, 1'h1);
    call(FN_MW, 8'h00, 8'h22, 2'h0, 2'h0, 1'h0, 1'h1, 9'h002);
    keyed(fwp_pkg::CMD_SET_WE, 1'h0, 1'h1);
    call(FN_MW, 8'h10, 8'h00, 2'h0, 2'h0, 1'h0, 1'h1, 9'h002);
    rd(fwp_pkg::ADDR_BOOT_STATUS_BYTE, v);
    chk("locked status", 8'hC0, v);
  endtask

  // Neither loader nor call mode: no guard, clear command unlocks
  task automatic t_prog_mode();
    @(posedge ref_clk);
    application_call_mode <= 1'h0;
    call(FN_MW, 8'h00, 8'h33, 2'h1, 2'h0, 1'h1, 1'h0, 9'h000);
    call(FN_MW, 8'h10, 8'h00, 2'h1, 2'h0, 1'h0, 1'h0, 9'h000);
    rd(fwp_pkg::ADDR_BOOT_STATUS_BYTE, v);
    chk("cleared status", 8'h00, v);
    chk("forced again", 8'h01, {7'h00, write_enable});
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'h1;
    t_reset_state();
    t_page_prog();
    t_missing_key();
    t_loader_writes();
    t_key_seq();
    t_call_mode();
    t_prog_mode();
    end_of_test();
  end

  // Cut a hang short
  initial begin
    #1_000_000;
    fail_count++;
    $display("FAIL watchdog expected done seen hang");
    end_of_test();
  end
endmodule
`default_nettype wire
